/* src/supply_regulator_and_battery_monitor.sv */
// Operation
// - Analog bypass bit 7 set disables the analog regulator; reset zero keeps it on.
// - Analog settled bit 6 shows stable supply; forced one under analog bypass.
// - Digital bypass bit 3 set disables the digital regulator; reset zero keeps it on.
// - Digital settled bit 2 shows stable supply; forced one under digital bypass.
// - Digital settled resets to zero, reads one in practice.
// - Supply compared continuously; dropping below clears ok flag and requests interrupt.
// - Read-only above-threshold bit 5 of monitor register, reset zero.
// - Range bit 4 picks high 75mV steps or low 50mV steps.
// - Threshold code bits 3:0, reset 0x2, linear from 2.550 V or 1.70 V.
// - Interrupt only on one-to-zero transition of above-threshold flag.
// - No interrupt when flag never was one or stays zero after rewrite.
// - Comparison and interrupt inactive in power-on, sleep and deepest sleep.
// - Regulator control and status bits live at register 0x10.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module supply_regulator_and_battery_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [supply_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog front end, asynchronous
   input wire supply_pkg::analog_status_t analog_in,
   // Analog controls
   output logic analog_reg_bypass,
   output logic digital_reg_bypass,
   output logic [11:0] threshold_mv,
   output logic monitor_enable,
   // Interrupt
   output logic irq
);

   // Two-flop synchroniser; first stage read only by second
   supply_pkg::analog_status_t sync1_r, sync2_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= analog_in;
         sync2_r <= sync1_r;
      end
   end

   // Register state
   logic a_byp_r, a_byp_nxt, d_byp_r, d_byp_nxt;
   logic range_r, range_nxt;
   logic [3:0] code_r, code_nxt;
   logic [1:0] pwr_r, pwr_nxt;
   logic ok_r, ok_nxt;
   logic [7:0] ists_r, ists_nxt, imask_r, imask_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // Decode
   logic wr_acc, rd_acc, mapped, low_event;
   logic [7:0] idx;
   logic [7:0] reg_val, mon_val, rd_val;
   logic active;
   logic a_ok, d_ok;

   assign idx = paddr[supply_pkg::ADDR_W-1:2];
   assign wr_acc = psel && penable && pwrite && pstrb[0];
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (idx == supply_pkg::REG_IDX_REGULATOR) || (idx == supply_pkg::REG_IDX_MONITOR)
      || (idx == supply_pkg::REG_IDX_IRQ_STATUS) || (idx == supply_pkg::REG_IDX_IRQ_MASK)
      || (idx == supply_pkg::REG_IDX_POWER);
   // Zero wait states, so the answer always comes in the access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Monitor only runs while the transceiver is awake
   assign active = (supply_pkg::power_state_t'(pwr_r) == supply_pkg::PWR_ACTIVE);

   // Settled flags forced high under bypass
   assign a_ok = a_byp_r | sync2_r.analog_settled;
   assign d_ok = d_byp_r | sync2_r.digital_settled;

   // Register images
   always_comb begin
      reg_val = '0;
      reg_val[supply_pkg::ANALOG_BYPASS_BIT] = a_byp_r;
      reg_val[supply_pkg::ANALOG_SETTLED_BIT] = a_ok;
      reg_val[supply_pkg::DIGITAL_BYPASS_BIT] = d_byp_r;
      reg_val[supply_pkg::DIGITAL_SETTLED_BIT] = d_ok;
      mon_val = '0;
      mon_val[supply_pkg::ABOVE_BIT] = ok_r;
      mon_val[supply_pkg::RANGE_BIT] = range_r;
      mon_val[supply_pkg::CODE_W-1:0] = code_r;
      unique case (idx)
         supply_pkg::REG_IDX_REGULATOR: rd_val = reg_val;
         supply_pkg::REG_IDX_MONITOR: rd_val = mon_val;
         supply_pkg::REG_IDX_IRQ_STATUS: rd_val = ists_r;
         supply_pkg::REG_IDX_IRQ_MASK: rd_val = imask_r;
         supply_pkg::REG_IDX_POWER: rd_val = {6'h00, pwr_r};
         default: rd_val = '0;
      endcase
   end

   // Threshold from range and code, linear
   always_comb begin
      if (range_r) begin
         threshold_mv = supply_pkg::HIGH_BASE_MV
            + 12'(supply_pkg::HIGH_STEP_MV * {8'h00, code_r});
      end else begin
         threshold_mv = supply_pkg::LOW_BASE_MV
            + 12'(supply_pkg::LOW_STEP_MV * {8'h00, code_r});
      end
   end

   // Falling edge of ok flag is the only interrupt source
   assign low_event = active && ok_r && !sync2_r.supply_above;

   // Regulator bypass; both clear at reset so the regulators start enabled
   always_comb begin
      a_byp_nxt = a_byp_r;
      d_byp_nxt = d_byp_r;
      if (wr_acc && idx == supply_pkg::REG_IDX_REGULATOR) begin
         a_byp_nxt = pwdata[supply_pkg::ANALOG_BYPASS_BIT];
         d_byp_nxt = pwdata[supply_pkg::DIGITAL_BYPASS_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         a_byp_r <= 1'b0;
         d_byp_r <= 1'b0;
      end else begin
         a_byp_r <= a_byp_nxt;
         d_byp_r <= d_byp_nxt;
      end
   end

   // Monitor range and code; the above bit is read-only and ignores writes
   always_comb begin
      range_nxt = range_r;
      code_nxt = code_r;
      if (wr_acc && idx == supply_pkg::REG_IDX_MONITOR) begin
         range_nxt = pwdata[supply_pkg::RANGE_BIT];
         code_nxt = pwdata[supply_pkg::CODE_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         range_r <= 1'b0;
         code_r <= supply_pkg::CODE_RESET;
      end else begin
         range_r <= range_nxt;
         code_r <= code_nxt;
      end
   end

   // Power state; starts in power-on so the monitor waits for software
   always_comb begin
      pwr_nxt = pwr_r;
      if (wr_acc && idx == supply_pkg::REG_IDX_POWER) begin
         pwr_nxt = pwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwr_r <= supply_pkg::PWR_ON_RESET;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // Flag frozen while asleep, so a drop during sleep raises the event once the monitor is active again
   always_comb begin
      ok_nxt = active ? sync2_r.supply_above : ok_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ok_r <= 1'b0;
      end else begin
         ok_r <= ok_nxt;
      end
   end

   // Status and mask; a read clears status, but an event in that cycle wins
   always_comb begin
      imask_nxt = imask_r;
      ists_nxt = ists_r;
      if (wr_acc && idx == supply_pkg::REG_IDX_IRQ_MASK) begin
         imask_nxt = pwdata[7:0];
      end
      if (rd_acc && idx == supply_pkg::REG_IDX_IRQ_STATUS) begin
         ists_nxt = '0;
      end
      if (low_event) begin
         ists_nxt[supply_pkg::LOW_EVENT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ists_r <= '0;
         imask_r <= '0;
      end else begin
         ists_r <= ists_nxt;
         imask_r <= imask_nxt;
      end
   end

   // Last read value, held on the bus between reads
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_acc) begin
         rdata_nxt = {24'h00_0000, rd_val};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Read data is combinational view of the registered image for same-edge sampling
   assign prdata = (rd_acc) ? {24'h00_0000, rd_val} : rdata_r;
   assign analog_reg_bypass = a_byp_r;
   assign digital_reg_bypass = d_byp_r;
   assign monitor_enable = active;
   assign irq = |(ists_r & imask_r);

   // Checks on regulator bits and settled flags
   AST_ANALOG_BYPASS: assert property (@(posedge clk) disable iff (rst)
      wr_acc && idx == supply_pkg::REG_IDX_REGULATOR
      |=> analog_reg_bypass == $past(pwdata[supply_pkg::ANALOG_BYPASS_BIT]))
      else $error("analog bypass not taken");
   AST_DIGITAL_BYPASS: assert property (@(posedge clk) disable iff (rst)
      wr_acc && idx == supply_pkg::REG_IDX_REGULATOR
      |=> digital_reg_bypass == $past(pwdata[supply_pkg::DIGITAL_BYPASS_BIT]))
      else $error("digital bypass not taken");
   AST_ANALOG_FORCED: assert property (@(posedge clk) disable iff (rst)
      a_byp_r |-> reg_val[supply_pkg::ANALOG_SETTLED_BIT])
      else $error("analog settled not forced");
   AST_DIGITAL_FORCED: assert property (@(posedge clk) disable iff (rst)
      d_byp_r |-> reg_val[supply_pkg::DIGITAL_SETTLED_BIT])
      else $error("digital settled not forced");
   AST_ANALOG_TRACK: assert property (@(posedge clk) disable iff (rst)
      !a_byp_r
      |-> reg_val[supply_pkg::ANALOG_SETTLED_BIT] == sync2_r.analog_settled)
      else $error("analog settled not from supply");
   AST_DIGITAL_TRACK: assert property (@(posedge clk) disable iff (rst)
      !d_byp_r
      |-> reg_val[supply_pkg::DIGITAL_SETTLED_BIT] == sync2_r.digital_settled)
      else $error("digital settled not from supply");
   AST_REG_READ: assert property (@(posedge clk) disable iff (rst)
      rd_acc && idx == supply_pkg::REG_IDX_REGULATOR
      |-> prdata[supply_pkg::ANALOG_BYPASS_BIT] == a_byp_r
         && prdata[supply_pkg::DIGITAL_BYPASS_BIT] == d_byp_r)
      else $error("regulator register not at its index");

   // Checks on the threshold setting
   AST_RANGE_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_acc && idx == supply_pkg::REG_IDX_MONITOR
      |=> range_r == $past(pwdata[supply_pkg::RANGE_BIT]))
      else $error("range not taken");
   AST_CODE_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_acc && idx == supply_pkg::REG_IDX_MONITOR
      |=> code_r == $past(pwdata[supply_pkg::CODE_W-1:0]))
      else $error("code not taken");
   AST_THRESH: assert property (@(posedge clk) disable iff (rst)
      range_r && code_r == 4'hF |-> threshold_mv == 12'd3675)
      else $error("threshold table wrong");
   AST_LOW_DEFAULT: assert property (@(posedge clk) disable iff (rst)
      !range_r && code_r == supply_pkg::CODE_RESET
      |-> threshold_mv == 12'd1800)
      else $error("low range default wrong");
   AST_HIGH_BASE: assert property (@(posedge clk) disable iff (rst)
      range_r && code_r == 4'h0
      |-> threshold_mv == supply_pkg::HIGH_BASE_MV)
      else $error("high range base wrong");
   AST_STROBE_OFF: assert property (@(posedge clk) disable iff (rst)
      psel && penable && pwrite && !pstrb[0]
      |=> $stable(code_r) && $stable(range_r) && $stable(a_byp_r))
      else $error("write with byte strobe off took effect");

   // Checks on the flag and the low supply event
   AST_TRACK: assert property (@(posedge clk) disable iff (rst)
      active |=> ok_r == $past(sync2_r.supply_above))
      else $error("flag not tracking");
   AST_ABOVE_READ: assert property (@(posedge clk) disable iff (rst)
      rd_acc && idx == supply_pkg::REG_IDX_MONITOR
      |-> prdata[supply_pkg::ABOVE_BIT] == ok_r)
      else $error("above flag not on read data");
   AST_EVENT_ON_FALL: assert property (@(posedge clk) disable iff (rst)
      $rose(ists_r[supply_pkg::LOW_EVENT_BIT]) |-> $past(ok_r) && !ok_r)
      else $error("event without falling flag");
   AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
      low_event |=> ists_r[supply_pkg::LOW_EVENT_BIT])
      else $error("event lost");
   AST_NO_EVENT_ZERO: assert property (@(posedge clk) disable iff (rst)
      !ok_r && !ists_r[supply_pkg::LOW_EVENT_BIT] ##1 !ok_r
      |-> !ists_r[supply_pkg::LOW_EVENT_BIT])
      else $error("event while flag low");
   AST_SLEEP_QUIET: assert property (@(posedge clk) disable iff (rst)
      !active |=> ok_r == $past(ok_r))
      else $error("monitor active while asleep");
   AST_NO_EVENT_ASLEEP: assert property (@(posedge clk) disable iff (rst)
      !active |=> !$rose(ists_r[supply_pkg::LOW_EVENT_BIT]))
      else $error("event while asleep");
   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
      ists_r[supply_pkg::LOW_EVENT_BIT] && imask_r[supply_pkg::LOW_EVENT_BIT] |-> irq)
      else $error("unmasked event without interrupt");
   AST_READ_CLEAR: assert property (@(posedge clk) disable iff (rst)
      rd_acc && idx == supply_pkg::REG_IDX_IRQ_STATUS && !low_event
      |=> ists_r == 8'h00)
      else $error("status not cleared by read");

   // Checks on the bus and the synchroniser
   AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
      rd_acc |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (rst)
      psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   AST_SYNC: assert property (@(posedge clk) disable iff (rst)
      ##2 sync2_r == $past(analog_in, 2))
      else $error("synchroniser depth wrong");

   // Main scenarios
   COV_LOW: cover property (@(posedge clk) disable iff (rst) low_event);
   COV_IRQ: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   COV_BYPASS: cover property (@(posedge clk) disable iff (rst) a_byp_r && d_byp_r);
   COV_SLEEP_DROP: cover property (@(posedge clk) disable iff (rst)
      !active && ok_r && !sync2_r.supply_above);
   COV_READ_CLEAR: cover property (@(posedge clk) disable iff (rst)
      rd_acc && idx == supply_pkg::REG_IDX_IRQ_STATUS && ists_r[supply_pkg::LOW_EVENT_BIT]);

endmodule

`default_nettype wire

/* src/supply_pkg.sv */
package supply_pkg;

   // Register indexes; the byte address on the bus is four times the index
   localparam logic [7:0] REG_IDX_REGULATOR = 8'h10;
   localparam logic [7:0] REG_IDX_MONITOR = 8'h11;
   localparam logic [7:0] REG_IDX_IRQ_STATUS = 8'h12;
   localparam logic [7:0] REG_IDX_IRQ_MASK = 8'h13;
   localparam logic [7:0] REG_IDX_POWER = 8'h14;
   localparam int ADDR_W = 10;

   // Regulator register fields
   localparam int ANALOG_BYPASS_BIT = 7;
   localparam int ANALOG_SETTLED_BIT = 6;
   localparam int DIGITAL_BYPASS_BIT = 3;
   localparam int DIGITAL_SETTLED_BIT = 2;

   // Monitor register fields
   localparam int ABOVE_BIT = 5;
   localparam int RANGE_BIT = 4;
   localparam int CODE_W = 4;
   localparam logic [3:0] CODE_RESET = 4'h2;

   // Threshold tables in millivolts
   localparam logic [11:0] HIGH_BASE_MV = 12'd2550;
   localparam logic [11:0] HIGH_STEP_MV = 12'd75;
   localparam logic [11:0] LOW_BASE_MV = 12'd1700;
   localparam logic [11:0] LOW_STEP_MV = 12'd50;

   // Interrupt status bit for the low supply event
   localparam int LOW_EVENT_BIT = 0;

   // Transceiver power states that gate the monitor
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'h0,
      PWR_ON_RESET = 2'h1,
      PWR_SLEEP = 2'h2,
      PWR_DEEP = 2'h3
   } power_state_t;

   // Analog-side indications
   typedef struct packed {
      logic supply_above;
      logic analog_settled;
      logic digital_settled;
   } analog_status_t;

endpackage

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [supply_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   supply_pkg::analog_status_t analog_in = '0;
   logic analog_reg_bypass;
   logic digital_reg_bypass;
   logic [11:0] threshold_mv;
   logic monitor_enable;
   logic irq;
   int mismatches = 0;
   int compares = 0;
   logic [31:0] rd;
   logic err;
   // Byte addresses are the register index times four
   localparam logic [9:0] A_REG = {supply_pkg::REG_IDX_REGULATOR, 2'b00};
   localparam logic [9:0] A_MON = {supply_pkg::REG_IDX_MONITOR, 2'b00};
   localparam logic [9:0] A_STS = {supply_pkg::REG_IDX_IRQ_STATUS, 2'b00};
   localparam logic [9:0] A_MSK = {supply_pkg::REG_IDX_IRQ_MASK, 2'b00};
   localparam logic [9:0] A_PWR = {supply_pkg::REG_IDX_POWER, 2'b00};

   supply_regulator_and_battery_monitor supply_regulator_and_battery_monitor_i (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .analog_in(analog_in), .analog_reg_bypass(analog_reg_bypass),
      .digital_reg_bypass(digital_reg_bypass), .threshold_mv(threshold_mv),
      .monitor_enable(monitor_enable), .irq(irq));

   // Free running clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check(1'b0, 1'b1, "pready timeout");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [9:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp, what);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Reset state, regulator bypass forcing, refused accesses
   task automatic test_regulator;
      rchk(A_REG, 32'h0000_0000, "regulator reset");
      rchk(A_MON, 32'h0000_0002, "monitor reset");
      check(threshold_mv, 12'd1800, "threshold reset");
      check(monitor_enable, 1'b0, "monitor off at power-on");
      apb(1'b1, A_REG, 32'h0000_0088);
      check(analog_reg_bypass, 1'b1, "analog bypass out");
      check(digital_reg_bypass, 1'b1, "digital bypass out");
      rchk(A_REG, 32'h0000_00cc, "settled forced");
      apb(1'b1, A_REG, 32'h0000_0000);
      analog_in <= 3'b011;
      wait_clk(5);
      rchk(A_REG, 32'h0000_0044, "settled from supply");
      pstrb <= 4'h0;
      apb(1'b1, A_REG, 32'h0000_0080);
      pstrb <= 4'hf;
      rchk(A_REG, 32'h0000_0044, "strobe zero ignored");
      rchk(10'h3fc, 32'h0000_0000, "unmapped read");
      check(err, 1'b1, "unmapped error");
      $display("test regulator done");
   endtask

   // Every code in both ranges
   task automatic test_table;
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 16; c++) begin
            apb(1'b1, A_MON, 32'(r * 16 + c));
            check(threshold_mv, r ? 2550 + 75 * c : 1700 + 50 * c, "threshold");
            rchk(A_MON, 32'(r * 16 + c), "monitor readback");
         end
      end
      $display("test table done");
   endtask

   // Flag, falling-edge event, mask, clear on read, inactive states
   task automatic test_monitor;
      analog_in <= 3'b111;
      wait_clk(6);
      rchk(A_MON, 32'h0000_001f, "frozen while power-on");
      rchk(A_STS, 32'h0000_0000, "no event at power-on");
      apb(1'b1, A_MSK, 32'h0000_0001);
      apb(1'b1, A_PWR, 32'h0000_0000);
      wait_clk(6);
      check(monitor_enable, 1'b1, "monitor active");
      rchk(A_MON, 32'h0000_003f, "flag above");
      analog_in <= 3'b011;
      wait_clk(6);
      check(irq, 1'b1, "irq on fall");
      rchk(A_MON, 32'h0000_001f, "flag below");
      rchk(A_STS, 32'h0000_0001, "status set");
      wait_clk(1);
      check(irq, 1'b0, "irq cleared by read");
      apb(1'b1, A_MON, 32'h0000_0000);
      analog_in <= 3'b011;
      wait_clk(6);
      rchk(A_STS, 32'h0000_0000, "no event while low");
      rchk(A_MON, 32'h0000_0000, "flag after new threshold");
      analog_in <= 3'b111;
      wait_clk(6);
      rchk(A_STS, 32'h0000_0000, "no event on rise");
      apb(1'b1, A_MSK, 32'h0000_0000);
      analog_in <= 3'b011;
      wait_clk(6);
      check(irq, 1'b0, "masked irq");
      rchk(A_STS, 32'h0000_0001, "masked status");
      analog_in <= 3'b111;
      wait_clk(6);
      apb(1'b1, A_PWR, 32'h0000_0002);
      check(monitor_enable, 1'b0, "monitor off in sleep");
      wait_clk(6);
      analog_in <= 3'b011;
      wait_clk(6);
      rchk(A_STS, 32'h0000_0000, "no event in sleep");
      $display("test monitor done");
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence; reset held for 20 cycles
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_regulator;
      test_table;
      test_monitor;
      stop_test;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test;
   end
endmodule
`default_nettype wire
